// [logic/irqtr_pkg.sv]
// package for the irq trigger and coprocessor error block
// assumes a 32-bit apb slave port and a 16-bit byte address
package irqtr_pkg;
  // printed offsets, kept as register indices
  localparam logic [15:0] IDX_CLR = 16'h00f0;
  localparam logic [15:0] IDX_TRIG_LO = 16'h04d0;
  localparam logic [15:0] IDX_TRIG_HI = 16'h04d1;
  // block's own registers, as indices
  localparam logic [15:0] IDX_CTRL = 16'h0500;
  localparam logic [15:0] IDX_STAT = 16'h0501;
  localparam logic [15:0] IDX_MASK = 16'h0502;
  localparam logic [15:0] IDX_PINS = 16'h0503;
  localparam logic [15:0] IDX_PEND = 16'h0504;
  // byte addresses are four times the index
  localparam logic [15:0] ADDR_CLR = IDX_CLR << 2;
  localparam logic [15:0] ADDR_TRIG_LO = IDX_TRIG_LO << 2;
  localparam logic [15:0] ADDR_TRIG_HI = IDX_TRIG_HI << 2;
  localparam logic [15:0] ADDR_CTRL = IDX_CTRL << 2;
  localparam logic [15:0] ADDR_STAT = IDX_STAT << 2;
  localparam logic [15:0] ADDR_MASK = IDX_MASK << 2;
  localparam logic [15:0] ADDR_PINS = IDX_PINS << 2;
  localparam logic [15:0] ADDR_PEND = IDX_PEND << 2;
  // isa i/o address of the clear port as forwarded
  localparam logic [15:0] ISA_CLR_PORT = 16'h00f0;
  // field positions and writable masks
  localparam int CTRL_FPU_EN_BIT = 5;
  localparam logic [7:0] TRIG_LO_WMASK = 8'hf8;
  localparam logic [7:0] TRIG_HI_WMASK = 8'hde;
  localparam logic [7:0] TRIG_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // status / mask layout
  localparam int EV_RAISED = 0;
  localparam int EV_IGNORE = 1;
  localparam int EV_CLR_NOP = 2;
  localparam int EV_EDGE = 3;
  localparam int NUM_EV = 4;
  localparam int NUM_IRQ = 16;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RAISED = 3'b010,
    ST_IGNORE = 3'b100
  } irqtr_fpu_st_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] data;
  } irqtr_isa_fwd_t;
endpackage : irqtr_pkg

// [logic/irqtr_top.sv]
// irq trigger select and coprocessor error reporting, apb slave
// assumes pins are asynchronous to pclk; isa side takes one-cycle forward pulses
// Behaviour
// - error reporting works only while control bit 5 is one
// - when enabled, error input assertion raises the numeric error irq
// - clear write during error asserts ignore output and drops the irq
// - ignore output stays asserted until the error input negates
// - clear write without error leaves the ignore output unchanged
// - any data written to the clear port counts as the clear
// - reads and writes of the clear port are forwarded to isa
// - select bit zero means edge trigger, one means level trigger
// - inputs 0,1,2,8,13 stay edge; their bits read zero
// - both select registers reset to zero, all edge triggered
// - low register holds inputs 0-7, high register inputs 8-15
module irqtr_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // coprocessor pins
  input wire logic coproc_error_in_n,
  output logic ignore_numeric_error_out_n,
  output logic numeric_error_irq,
  // interrupt inputs and trigger outputs
  input wire logic [15:0] irq_in,
  output logic [15:0] trigger_level,
  output logic [15:0] irq_pending,
  // isa forwarding
  output irqtr_pkg::irqtr_isa_fwd_t isa_fwd,
  // summary interrupt
  output logic irq
);
  logic setup;
  logic access;
  logic wr_en;
  logic rd_setup;
  logic hit_clr;
  logic hit_lo;
  logic hit_hi;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic hit_pins;
  logic hit_pend;
  logic mapped;
  logic clr_wr;
  logic fpu_en;
  logic err_s1_q;
  logic err_s2_q;
  logic err_prev_q;
  logic err;
  logic err_rise;
  logic [15:0] irq_s1_q;
  logic [15:0] irq_s2_q;
  logic [15:0] irq_prev_q;
  logic [15:0] edge_lat_q;
  logic [15:0] pend_d;
  logic [7:0] trig_lo_q;
  logic [7:0] trig_hi_q;
  logic [7:0] ctrl_q;
  logic [3:0] stat_q;
  logic [3:0] mask_q;
  logic [3:0] ev;
  logic [31:0] rdata_d;
  irqtr_pkg::irqtr_fpu_st_t st_q;
  irqtr_pkg::irqtr_fpu_st_t st_d;

  // apb decode; one wait state lets prdata come from a flop
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr_en = access & pwrite;
  assign rd_setup = setup & ~pwrite;
  assign hit_clr = paddr == irqtr_pkg::ADDR_CLR;
  assign hit_lo = paddr == irqtr_pkg::ADDR_TRIG_LO;
  assign hit_hi = paddr == irqtr_pkg::ADDR_TRIG_HI;
  assign hit_ctrl = paddr == irqtr_pkg::ADDR_CTRL;
  assign hit_stat = paddr == irqtr_pkg::ADDR_STAT;
  assign hit_mask = paddr == irqtr_pkg::ADDR_MASK;
  assign hit_pins = paddr == irqtr_pkg::ADDR_PINS;
  assign hit_pend = paddr == irqtr_pkg::ADDR_PEND;
  assign mapped = hit_clr | hit_lo | hit_hi | hit_ctrl | hit_stat | hit_mask | hit_pins | hit_pend;
  // data bits are ignored on purpose
  assign clr_wr = wr_en & hit_clr;
  assign fpu_en = ctrl_q[irqtr_pkg::CTRL_FPU_EN_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~mapped;
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_lo) begin
      rdata_d[7:0] = trig_lo_q;
    end else if (hit_hi) begin
      rdata_d[7:0] = trig_hi_q;
    end else if (hit_ctrl) begin
      rdata_d[7:0] = ctrl_q;
    end else if (hit_stat) begin
      rdata_d[3:0] = stat_q;
    end else if (hit_mask) begin
      rdata_d[3:0] = mask_q;
    end else if (hit_pins) begin
      // write-only clear port reads zero; live pin view here instead
      rdata_d[15:0] = irq_s2_q;
      rdata_d[16] = err;
      rdata_d[17] = st_q == irqtr_pkg::ST_RAISED;
      rdata_d[18] = st_q == irqtr_pkg::ST_IGNORE;
    end else if (hit_pend) begin
      rdata_d[15:0] = pend_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rdata_d;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // trigger select registers; reserved bits never store a one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_lo_q <= irqtr_pkg::TRIG_RESET;
      trig_hi_q <= irqtr_pkg::TRIG_RESET;
    end else if (wr_en) begin
      if (hit_lo) begin
        trig_lo_q <= pwdata[7:0] & irqtr_pkg::TRIG_LO_WMASK;
      end
      if (hit_hi) begin
        trig_hi_q <= pwdata[7:0] & irqtr_pkg::TRIG_HI_WMASK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= irqtr_pkg::CTRL_RESET;
    end else if (wr_en && hit_ctrl) begin
      ctrl_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 4'h0;
    end else if (wr_en && hit_mask) begin
      mask_q <= pwdata[3:0];
    end
  end

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_s1_q <= 1'b0;
      err_s2_q <= 1'b0;
    end else begin
      err_s1_q <= ~coproc_error_in_n;
      err_s2_q <= err_s1_q;
    end
  end

  // history resets to the idle level, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_prev_q <= 1'b0;
    end else begin
      err_prev_q <= err_s2_q;
    end
  end
  assign err = err_s2_q;
  assign err_rise = err_s2_q & ~err_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < irqtr_pkg::NUM_IRQ; gi++) begin : g_irq
      logic lvl;
      if (gi < 8) begin : g_lo
        assign lvl = trig_lo_q[gi];
      end else begin : g_hi
        assign lvl = trig_hi_q[gi - 8];
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_s1_q[gi] <= 1'b0;
          irq_s2_q[gi] <= 1'b0;
          irq_prev_q[gi] <= 1'b0;
        end else begin
          irq_s1_q[gi] <= irq_in[gi];
          irq_s2_q[gi] <= irq_s1_q[gi];
          irq_prev_q[gi] <= irq_s2_q[gi];
        end
      end
      // a new edge beats a software ack in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          edge_lat_q[gi] <= 1'b0;
        end else if (!lvl && irq_s2_q[gi] && !irq_prev_q[gi]) begin
          edge_lat_q[gi] <= 1'b1;
        end else if (lvl || (wr_en && hit_pend && pwdata[gi])) begin
          edge_lat_q[gi] <= 1'b0;
        end
      end
      // level mode pends only while the input is high
      assign pend_d[gi] = lvl ? irq_s2_q[gi] : edge_lat_q[gi];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_level <= 16'h0000;
    end else begin
      trigger_level <= {trig_hi_q, trig_lo_q};
    end
  end

  // pending view lags the synced pins by one cycle in level mode, two in edge mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pending <= 16'h0000;
    end else begin
      irq_pending <= pend_d;
    end
  end

  // coprocessor error sequence
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      irqtr_pkg::ST_IDLE: begin
        if (fpu_en && clr_wr && err) begin
          st_d = irqtr_pkg::ST_IGNORE;
        end else if (fpu_en && err_rise) begin
          st_d = irqtr_pkg::ST_RAISED;
        end
      end
      irqtr_pkg::ST_RAISED: begin
        if (!fpu_en) begin
          st_d = irqtr_pkg::ST_IDLE;
        end else if (clr_wr && err) begin
          st_d = irqtr_pkg::ST_IGNORE;
        end
      end
      irqtr_pkg::ST_IGNORE: begin
        // held regardless of clear writes; only negation ends it
        if (!err) begin
          st_d = irqtr_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d = irqtr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= irqtr_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // irq drops on a clear while the error input is asserted or on disable, never on error negation alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      numeric_error_irq <= 1'b0;
    end else begin
      numeric_error_irq <= st_d == irqtr_pkg::ST_RAISED;
    end
  end

  // active low; idles high through and after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ignore_numeric_error_out_n <= 1'b1;
    end else begin
      ignore_numeric_error_out_n <= st_d != irqtr_pkg::ST_IGNORE;
    end
  end

  // clear port traffic goes out to isa as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isa_fwd <= '0;
    end else begin
      isa_fwd.valid <= access & hit_clr;
      isa_fwd.write <= pwrite;
      isa_fwd.addr <= irqtr_pkg::ISA_CLR_PORT;
      isa_fwd.data <= pwrite ? pwdata[7:0] : 8'h00;
    end
  end

  // events, sticky status, set wins over write-one-to-clear
  assign ev[irqtr_pkg::EV_RAISED] = st_q != irqtr_pkg::ST_RAISED && st_d == irqtr_pkg::ST_RAISED;
  assign ev[irqtr_pkg::EV_IGNORE] = st_q != irqtr_pkg::ST_IGNORE && st_d == irqtr_pkg::ST_IGNORE;
  assign ev[irqtr_pkg::EV_CLR_NOP] = clr_wr & ~(fpu_en & err);
  assign ev[irqtr_pkg::EV_EDGE] = |(irq_s2_q & ~irq_prev_q & ~{trig_hi_q, trig_lo_q});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 4'h0;
    end else if (wr_en && hit_stat) begin
      stat_q <= (stat_q & ~pwdata[3:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end
endmodule : irqtr_top

// [tb/irqtr_properties.sv]
// checker for the irq trigger and coprocessor error block
// assumes it is bound to irqtr_top and sees only its ports
module irqtr_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // coprocessor pins
  input wire logic coproc_error_in_n,
  input wire logic ignore_numeric_error_out_n,
  input wire logic numeric_error_irq,
  // interrupt inputs and trigger outputs
  input wire logic [15:0] irq_in,
  input wire logic [15:0] trigger_level,
  input wire logic [15:0] irq_pending,
  // isa forwarding and summary
  input wire irqtr_pkg::irqtr_isa_fwd_t isa_fwd,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence clr_acc;
    psel && penable && pready && paddr == irqtr_pkg::ADDR_CLR;
  endsequence
  sequence clr_wr;
    psel && penable && pready && pwrite && paddr == irqtr_pkg::ADDR_CLR;
  endsequence
  // pin must settle past the two-stage synchroniser before it counts
  sequence err_held;
    (!coproc_error_in_n) [*3];
  endsequence
  sequence err_gone;
    coproc_error_in_n [*6];
  endsequence
  apb_one_wait_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  reserved_edge_a: assert property ((trigger_level & 16'h2107) == 16'h0000)
    else $error("reserved select bit set");
  clear_ignore_a: assert property (err_held ##0 clr_wr ##0 numeric_error_irq |->
    ##[1:2] (!ignore_numeric_error_out_n && !numeric_error_irq)) else $error("clear did not ignore");
  ignore_hold_a: assert property (err_held ##0 !ignore_numeric_error_out_n |=>
    !ignore_numeric_error_out_n) else $error("ignore dropped early");
  ignore_release_a: assert property (err_gone |-> ignore_numeric_error_out_n)
    else $error("ignore not released");
  clear_noerr_a: assert property (err_gone ##0 clr_wr |=> ignore_numeric_error_out_n [*2])
    else $error("clear changed ignore");
  isa_forward_a: assert property (clr_acc |=> isa_fwd.valid && isa_fwd.write == $past(pwrite) &&
    isa_fwd.addr == irqtr_pkg::ISA_CLR_PORT) else $error("clear port not forwarded");
  level_follow_a: assert property (($stable(irq_in) && $stable(trigger_level)) [*4] |->
    ((irq_pending ^ irq_in) & trigger_level) == 16'h0000) else $error("level pending wrong");
endmodule : irqtr_properties

// [tb/irqtr_copro_model.sv]
// coprocessor model driving the active-low error pin
// assumes the bench raises err_req to signal a numeric fault
module irqtr_copro_model (
  // clock
  input wire logic pclk,
  // request from the bench
  input wire logic err_req,
  // pin to the block
  output logic coproc_error_in_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial coproc_error_in_n = 1'b1;
  // fault held until the handler lets go; plain always so the pin idles high from time zero
  always @(posedge pclk) coproc_error_in_n <= !err_req;
endmodule : irqtr_copro_model

// [tb/irqtr_top_tb.sv]
// self-checking bench for irqtr_top
// assumes the one-wait-state apb slave described for the block
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("Error %s exp %h got %h", n, e, g); end end
module irqtr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, err_req, pready, pslverr, er;
  logic ignore_numeric_error_out_n, numeric_error_irq, irq, coproc_error_in_n;
  logic [15:0] paddr, irq_in, trigger_level, irq_pending;
  logic [31:0] pwdata, prdata, rd;
  irqtr_pkg::irqtr_isa_fwd_t isa_fwd, isa_seen;
  int fails, comparisons, isa_n, n;
  irqtr_top irqtr_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .coproc_error_in_n, .ignore_numeric_error_out_n, .numeric_error_irq, .irq_in,
    .trigger_level, .irq_pending, .isa_fwd, .irq);
  irqtr_copro_model irqtr_copro_model_inst (.pclk, .err_req, .coproc_error_in_n);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (isa_fwd.valid === 1'b1) begin
      isa_n++;
      isa_seen = isa_fwd;
    end
  end
  // waits for pready however long it takes; only the watchdog ends a hang
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task t_reset;
    `CHK("ignore_n", 1'b1, ignore_numeric_error_out_n)
    apb(1'b0, irqtr_pkg::ADDR_TRIG_LO, 32'h0); `CHK("trig_lo", 32'h00000000, rd)
    apb(1'b0, irqtr_pkg::ADDR_TRIG_HI, 32'h0); `CHK("trig_hi", 32'h00000000, rd)
  endtask : t_reset
  task t_trig;
    apb(1'b1, irqtr_pkg::ADDR_TRIG_LO, 32'h000000ff);
    apb(1'b1, irqtr_pkg::ADDR_TRIG_HI, 32'h000000ff); // level select on pci-routed inputs
    apb(1'b0, irqtr_pkg::ADDR_TRIG_LO, 32'h0); `CHK("trig_lo", 32'h000000f8, rd)
    apb(1'b0, irqtr_pkg::ADDR_TRIG_HI, 32'h0); `CHK("trig_hi", 32'h000000de, rd)
    `CHK("trigger_level", 16'hdef8, trigger_level)
    irq_in <= 16'h0008; repeat (6) @(posedge pclk); `CHK("lvl_pend", 1'b1, irq_pending[3])
    irq_in <= 16'h0000; repeat (6) @(posedge pclk); `CHK("lvl_drop", 1'b0, irq_pending[3])
    apb(1'b1, irqtr_pkg::ADDR_TRIG_LO, 32'h0);
    irq_in <= 16'h0010; repeat (2) @(posedge pclk);
    irq_in <= 16'h0000; repeat (6) @(posedge pclk); `CHK("edge_pend", 1'b1, irq_pending[4])
    apb(1'b1, irqtr_pkg::ADDR_PEND, 32'h10); repeat (2) @(posedge pclk);
    `CHK("edge_ack", 1'b0, irq_pending[4])
  endtask : t_trig
  task t_off;
    apb(1'b1, irqtr_pkg::ADDR_CTRL, 32'h0); err_req <= 1'b1; repeat (8) @(posedge pclk);
    `CHK("irq_off", 1'b0, numeric_error_irq)
    apb(1'b1, irqtr_pkg::ADDR_CLR, 32'h0); repeat (3) @(posedge pclk);
    `CHK("ign_off", 1'b1, ignore_numeric_error_out_n)
    err_req <= 1'b0; repeat (6) @(posedge pclk);
  endtask : t_off
  task t_fpu;
    apb(1'b1, irqtr_pkg::ADDR_CTRL, 32'h20); err_req <= 1'b1; repeat (8) @(posedge pclk);
    `CHK("fpu_irq", 1'b1, numeric_error_irq)
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, irqtr_pkg::ADDR_MASK, 32'h1); repeat (2) @(posedge pclk); `CHK("irq_on", 1'b1, irq)
    apb(1'b1, irqtr_pkg::ADDR_STAT, 32'h1); repeat (2) @(posedge pclk); `CHK("irq_w1c", 1'b0, irq)
    n = isa_n;
    apb(1'b1, irqtr_pkg::ADDR_CLR, 32'h5a); repeat (3) @(posedge pclk);
    `CHK("irq_clr", 1'b0, numeric_error_irq)
    `CHK("ign_on", 1'b0, ignore_numeric_error_out_n)
    `CHK("isa_data", 8'h5a, isa_seen.data)
    `CHK("isa_addr", irqtr_pkg::ISA_CLR_PORT, isa_seen.addr)
    `CHK("isa_wr", 1'b1, isa_seen.write)
    apb(1'b0, irqtr_pkg::ADDR_CLR, 32'h0); repeat (2) @(posedge pclk);
    `CHK("clr_rd", 32'h00000000, rd)
    `CHK("isa_fwd", n + 2, isa_n)
    `CHK("isa_rd", 1'b0, isa_seen.write)
    apb(1'b0, irqtr_pkg::ADDR_STAT, 32'h0); `CHK("stat", 32'h0000000e, rd)
    repeat (10) @(posedge pclk); `CHK("ign_hold", 1'b0, ignore_numeric_error_out_n)
    apb(1'b0, irqtr_pkg::ADDR_PINS, 32'h0); `CHK("pins", 32'h00050000, rd)
    err_req <= 1'b0; repeat (8) @(posedge pclk);
    `CHK("ign_rel", 1'b1, ignore_numeric_error_out_n)
    apb(1'b1, irqtr_pkg::ADDR_CLR, 32'h0); repeat (3) @(posedge pclk);
    `CHK("ign_noerr", 1'b1, ignore_numeric_error_out_n)
  endtask : t_fpu
  task t_bad;
    apb(1'b0, 16'h2000, 32'h0);
    `CHK("slverr", 1'b1, er)
    `CHK("bad_rd", 32'h00000000, rd)
  endtask : t_bad
  task conclude;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0000;
    pwdata = 32'h0; irq_in = 16'h0000; err_req = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_trig();
    t_off();
    t_fpu();
    t_bad();
    conclude();
  end
  // whole run is about 150 cycles, so this leaves wide margin
  initial begin
    #(25 * 20000);
    fails++;
    conclude();
  end
endmodule : irqtr_top_tb
bind irqtr_top irqtr_properties irqtr_properties_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .coproc_error_in_n, .ignore_numeric_error_out_n,
  .numeric_error_irq, .irq_in, .trigger_level, .irq_pending, .isa_fwd, .irq);
